/* File: include/dbg_consts.svh */
`ifndef DBG_CONSTS_SVH
`define DBG_CONSTS_SVH

// ---------------------------------------------------------------
// Control access port register offsets (byte addresses)
// ---------------------------------------------------------------
`define OFS_SOFT_RESET  8'h00
`define OFS_ERASE_CMD   8'h04
`define OFS_ERASE_STAT  8'h08
`define OFS_PROT_STAT   8'h0c
`define OFS_PORT_ID     8'hfc

// ---------------------------------------------------------------
// Field values
// ---------------------------------------------------------------
`define CMD_BIT         0
`define PROT_OFF_VALUE  8'hff
`define ERASED_WORD     32'hffffffff
`define CFG_WORD_ADDR   0
`define CLASS_UNDEF     4'h0
`define CLASS_MEM       4'h8
`define ID_RESERVED     5'h00
`define AP_SEL_CPU      1'b0
`define AP_SEL_CTRL     1'b1

`endif

/* File: include/dbg_pkg.sv */
package dbg_pkg;

  // Access sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b01,
    ST_CPU_WAIT = 2'b10
  } access_state_t;

  // One access port request as captured on the link side
  typedef struct packed {
    logic        write;
    logic        sel;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } ap_req_t;

endpackage : dbg_pkg

/* File: include/erase_mem_if.sv */
`timescale 1ns/1ps

// Carrier between the access logic and the erasable store
interface erase_mem_if #(parameter int AW = 6);
  logic          start;
  logic          busy;
  logic          prog_we;
  logic [AW-1:0] prog_addr;
  logic [31:0]   prog_data;
  logic [AW-1:0] rd_addr;
  logic [31:0]   rd_data;

  modport ctrl (output start, prog_we, prog_addr, prog_data, rd_addr,
                input  busy, rd_data);
  modport mem  (input  start, prog_we, prog_addr, prog_data, rd_addr,
                output busy, rd_data);
endinterface : erase_mem_if

/* File: rtl/erase_mem.sv */
`timescale 1ns/1ps
`include "dbg_consts.svh"

// Flash, configuration area and RAM image with a word-serial full erase
module erase_mem #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  // Clock and reset
  input wire logic   sys_clk,
  input wire logic   rst,
  // Store port
  erase_mem_if.mem   port
);

  logic [31:0]   store [DEPTH];
  logic          busy_q;
  logic          busy_d;
  logic [AW-1:0] ptr_q;
  logic [AW-1:0] ptr_d;
  logic [31:0]   rd_data_q;

  if (DEPTH < 2 || DEPTH > (1 << AW)) begin : g_chk
    $error("erase_mem: DEPTH does not fit AW");
  end

  // Power-up image is erased; real parts ship blank
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      store[i] = `ERASED_WORD;
    end
  end

  // Erase walker: busy from the cycle after start until the last word is cleared
  always_comb begin
    busy_d = busy_q;
    ptr_d  = ptr_q;
    if (!busy_q && port.start) begin
      busy_d = 1'b1;                                  // R15
      ptr_d  = '0;
    end else if (busy_q) begin
      if (ptr_q == AW'(DEPTH - 1)) begin
        busy_d = 1'b0;
      end else begin
        ptr_d = ptr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      ptr_q  <= '0;
    end else begin
      busy_q <= busy_d;
      ptr_q  <= ptr_d;
    end
  end

  // Storage; programming is locked out while an erase runs
  always_ff @(posedge sys_clk) begin
    if (busy_q) begin
      store[ptr_q] <= `ERASED_WORD;
    end else if (port.prog_we) begin
      store[port.prog_addr] <= port.prog_data;
    end
    rd_data_q <= store[port.rd_addr];
  end

  assign port.busy    = busy_q;
  assign port.rd_data = rd_data_q;

endmodule : erase_mem

/* File: rtl/debug_control_access_port.sv */
`timescale 1ns/1ps
`include "dbg_consts.svh"

// What this block does
// (R1) Offer a CPU memory access port and a control access port via the link.
// (R2) With protection on, refuse all CPU memory access port requests.
// (R3) Control access port always answers, protection or not.
// (R4) Full erase clears flash, config area and RAM, lifting protection.
// (R5) Soft reset register bit 0 holds the device in reset while set.
// (R6) Writing 1 to erase command bit 0 starts erase; 0 does nothing.
// (R7) Erase status bit 0 reads 1 while erasing, 0 when ready.
// (R8) Protection status bit 0 reads 0 when protected, 1 when not.
// (R9) Identification register reports identifier, class, maker codes, revision.
// (R10) Debugger must raise power request before any access port access.
// (R11) Power request during System OFF wakes the device and sets wake flag.
// (R12) Debug interface mode lasts exactly while power request is held.
// (R13) Debugger drops power request at session end to leave debug mode.
// (R14) Protection is off when the config protection field reads all ones.
// (R15) Erase reads busy from the cycle after acceptance until fully cleared.
module debug_control_access_port #(
  parameter int         DEPTH       = 64,
  parameter logic [3:0] ID_REVISION = 4'h1,         // Arbitrary value
  parameter logic [3:0] ID_CONT     = 4'h0,         // Arbitrary value
  parameter logic [6:0] ID_MAKER    = 7'h15,        // Arbitrary value
  parameter logic [3:0] ID_CLASS    = `CLASS_UNDEF,
  parameter logic [7:0] ID_PORT_IDENTIFIER_FIELD     = 8'h01         // Arbitrary value
) (
  // System clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Link side, debugger clock domain
  input  wire logic        swd_clk,
  input  wire logic        ap_req,
  input  wire logic        ap_sel,
  input  wire logic        ap_write,
  input  wire logic [7:0]  ap_addr,
  input  wire logic [31:0] ap_wdata,
  input  wire logic        pwr_req,
  output logic             ap_done,
  output logic [31:0]      ap_rdata,
  output logic             ap_err,
  // CPU memory access port core
  output logic             cpu_req,
  output logic             cpu_write,
  output logic [7:0]       cpu_addr,
  output logic [31:0]      cpu_wdata,
  input  wire logic        cpu_ack,
  input  wire logic [31:0] cpu_rdata,
  // Store programming
  input  wire logic        prog_we,
  input  wire logic [$clog2(DEPTH)-1:0] prog_addr,
  input  wire logic [31:0] prog_data,
  // Power and reset management, erase and protection status
  input  wire logic        system_off,
  input  wire logic        wake_flag_clr,
  output logic             debug_mode,
  output logic             wake_req,
  output logic             debug_wake_flag,
  output logic             soft_reset_hold,
  output logic             erase_busy,
  output logic             prot_enabled
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [31:0] ID_WORD =
    {ID_REVISION, ID_CONT, ID_MAKER, ID_CLASS, `ID_RESERVED, ID_PORT_IDENTIFIER_FIELD}; // R9

  if (DEPTH < 2) begin : g_chk
    $error("debug_control_access_port: DEPTH below 2");
  end

  // ---------------------------------------------------------------
  // Erasable store
  // ---------------------------------------------------------------
  erase_mem_if #(.AW(AW)) em_bus ();

  erase_mem #(.DEPTH(DEPTH), .AW(AW)) u_store (
    .sys_clk (sys_clk),
    .rst     (rst),
    .port    (em_bus.mem)
  );

  // ---------------------------------------------------------------
  // Link domain
  // ---------------------------------------------------------------
  logic             lrst_s1_q;
  logic             lrst_q;
  dbg_pkg::ap_req_t hold_q,      hold_d;
  logic             req_tgl_q,   req_tgl_d;
  logic             ack_s1_q;
  logic             ack_s2_q;
  logic             ack_seen_q,  ack_seen_d;
  logic             ap_done_q,   ap_done_d;
  logic [31:0]      ap_rdata_q,  ap_rdata_d;
  logic             ap_err_q,    ap_err_d;
  logic [31:0]      rsp_data_q,  rsp_data_d;
  logic             rsp_err_q,   rsp_err_d;
  logic             ack_tgl_q,   ack_tgl_d;

  // Reset and answer toggle brought onto the debugger clock
  always_ff @(posedge swd_clk) begin
    lrst_s1_q <= rst;
    lrst_q    <= lrst_s1_q;
    ack_s1_q  <= ack_tgl_q;
    ack_s2_q  <= ack_s1_q;
  end

  // Capture a request and flag it by toggle; answer data is stable once the toggle lands
  always_comb begin
    hold_d     = hold_q;
    req_tgl_d  = req_tgl_q;
    ack_seen_d = ack_s2_q;
    ap_done_d  = ack_s2_q ^ ack_seen_q;
    ap_rdata_d = ap_rdata_q;
    ap_err_d   = ap_err_q;
    if (ap_req) begin
      hold_d    = '{write: ap_write, sel: ap_sel, addr: ap_addr, wdata: ap_wdata};
      req_tgl_d = ~req_tgl_q;
    end
    if (ap_done_d) begin
      ap_rdata_d = rsp_data_q;
      ap_err_d   = rsp_err_q;
    end
  end

  always_ff @(posedge swd_clk) begin
    if (lrst_q) begin
      hold_q     <= '0;
      req_tgl_q  <= 1'b0;
      ack_seen_q <= 1'b0;
      ap_done_q  <= 1'b0;
      ap_rdata_q <= '0;
      ap_err_q   <= 1'b0;
    end else begin
      hold_q     <= hold_d;
      req_tgl_q  <= req_tgl_d;
      ack_seen_q <= ack_seen_d;
      ap_done_q  <= ap_done_d;
      ap_rdata_q <= ap_rdata_d;
      ap_err_q   <= ap_err_d;
    end
  end

  // ---------------------------------------------------------------
  // System domain
  // ---------------------------------------------------------------
  logic                  req_s1_q;
  logic                  req_s2_q;
  logic                  pwr_s1_q;
  logic                  pwr_s2_q;
  logic                  new_req;
  dbg_pkg::access_state_t state_q,      state_d;
  logic                  req_seen_q,   req_seen_d;
  logic                  dbg_q,        dbg_d;
  logic                  wake_q,       wake_d;
  logic                  wake_flag_q,  wake_flag_d;
  logic                  soft_reset_q, soft_reset_d;
  logic                  erase_start_q, erase_start_d;
  logic                  prot_on_q,    prot_on_d;
  logic                  cpu_req_q,    cpu_req_d;
  logic                  cpu_write_q,  cpu_write_d;
  logic [7:0]            cpu_addr_q,   cpu_addr_d;
  logic [31:0]           cpu_wdata_q,  cpu_wdata_d;
  logic [31:0]           reg_rdata;

  // Two-flop synchronisers for the request toggle and the power request
  always_ff @(posedge sys_clk) begin
    req_s1_q <= req_tgl_q;
    req_s2_q <= req_s1_q;
    pwr_s1_q <= pwr_req;
    pwr_s2_q <= pwr_s1_q;
  end

  assign new_req = req_s2_q ^ req_seen_q;

  // Control access port read view; unmapped offsets read zero
  always_comb begin
    case (hold_q.addr)
      `OFS_SOFT_RESET: reg_rdata = {31'h0, soft_reset_q};
      `OFS_ERASE_STAT: reg_rdata = {31'h0, em_bus.busy};  // R7
      `OFS_PROT_STAT:  reg_rdata = {31'h0, !prot_on_q};   // R8
      `OFS_PORT_ID:    reg_rdata = ID_WORD;               // R9
      default:         reg_rdata = 32'h0;
    endcase
  end

  // Access sequencer, power mode and control registers
  always_comb begin
    state_d       = state_q;
    req_seen_d    = req_s2_q;
    dbg_d         = pwr_s2_q;                                     // R12
    wake_d        = 1'b0;
    wake_flag_d   = wake_flag_q;
    soft_reset_d  = soft_reset_q;
    erase_start_d = 1'b0;
    prot_on_d     = em_bus.rd_data[7:0] != `PROT_OFF_VALUE;      // R14
    cpu_req_d     = cpu_req_q;
    cpu_write_d   = cpu_write_q;
    cpu_addr_d    = cpu_addr_q;
    cpu_wdata_d   = cpu_wdata_q;
    rsp_data_d    = rsp_data_q;
    rsp_err_d     = rsp_err_q;
    ack_tgl_d     = ack_tgl_q;
    // Clear first so that a wake in the same cycle wins
    if (wake_flag_clr) begin
      wake_flag_d = 1'b0;
    end
    if (pwr_s2_q && !dbg_q && system_off) begin                   // R11
      wake_d      = 1'b1;
      wake_flag_d = 1'b1;
    end
    case (state_q)
      dbg_pkg::ST_IDLE: begin
        if (new_req) begin
          if (!dbg_q) begin                                       // R10
            rsp_data_d = 32'h0;
            rsp_err_d  = 1'b1;
            ack_tgl_d  = ~ack_tgl_q;
          end else if (hold_q.sel == `AP_SEL_CTRL) begin          // R3
            rsp_data_d = reg_rdata;
            rsp_err_d  = 1'b0;
            ack_tgl_d  = ~ack_tgl_q;
            if (hold_q.write && hold_q.addr == `OFS_SOFT_RESET) begin
              soft_reset_d = hold_q.wdata[`CMD_BIT];              // R5
            end
            if (hold_q.write && hold_q.addr == `OFS_ERASE_CMD &&
                hold_q.wdata[`CMD_BIT] && !em_bus.busy) begin
              erase_start_d = 1'b1;                               // R6
            end
          end else if (prot_on_q) begin                           // R2
            rsp_data_d = 32'h0;
            rsp_err_d  = 1'b1;
            ack_tgl_d  = ~ack_tgl_q;
          end else begin                                          // R1
            cpu_req_d   = 1'b1;
            cpu_write_d = hold_q.write;
            cpu_addr_d  = hold_q.addr;
            cpu_wdata_d = hold_q.wdata;
            state_d     = dbg_pkg::ST_CPU_WAIT;
          end
        end
      end
      dbg_pkg::ST_CPU_WAIT: begin
        if (cpu_ack) begin
          cpu_req_d  = 1'b0;
          rsp_data_d = cpu_rdata;
          rsp_err_d  = 1'b0;
          ack_tgl_d  = ~ack_tgl_q;
          state_d    = dbg_pkg::ST_IDLE;
        end
      end
      default: state_d = dbg_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q       <= dbg_pkg::ST_IDLE;
      req_seen_q    <= 1'b0;
      dbg_q         <= 1'b0;
      wake_q        <= 1'b0;
      wake_flag_q   <= 1'b0;
      soft_reset_q  <= 1'b0;
      erase_start_q <= 1'b0;
      prot_on_q     <= 1'b1;  // Safe side until the config word is read
      cpu_req_q     <= 1'b0;
      cpu_write_q   <= 1'b0;
      cpu_addr_q    <= 8'h00;
      cpu_wdata_q   <= 32'h0;
      rsp_data_q    <= 32'h0;
      rsp_err_q     <= 1'b0;
      ack_tgl_q     <= 1'b0;
    end else begin
      state_q       <= state_d;
      req_seen_q    <= req_seen_d;
      dbg_q         <= dbg_d;
      wake_q        <= wake_d;
      wake_flag_q   <= wake_flag_d;
      soft_reset_q  <= soft_reset_d;
      erase_start_q <= erase_start_d;
      prot_on_q     <= prot_on_d;
      cpu_req_q     <= cpu_req_d;
      cpu_write_q   <= cpu_write_d;
      cpu_addr_q    <= cpu_addr_d;
      cpu_wdata_q   <= cpu_wdata_d;
      rsp_data_q    <= rsp_data_d;
      rsp_err_q     <= rsp_err_d;
      ack_tgl_q     <= ack_tgl_d;
    end
  end

  // ---------------------------------------------------------------
  // Store hookup and outputs
  // ---------------------------------------------------------------
  // Config word is read every cycle so protection drops two cycles after the erase clears word 0
  assign em_bus.start     = erase_start_q;                        // R4
  assign em_bus.prog_we   = prog_we;
  assign em_bus.prog_addr = prog_addr;
  assign em_bus.prog_data = prog_data;
  assign em_bus.rd_addr   = AW'(`CFG_WORD_ADDR);

  assign ap_done         = ap_done_q;
  assign ap_rdata        = ap_rdata_q;
  assign ap_err          = ap_err_q;
  assign cpu_req         = cpu_req_q;
  assign cpu_write       = cpu_write_q;
  assign cpu_addr        = cpu_addr_q;
  assign cpu_wdata       = cpu_wdata_q;
  assign debug_mode      = dbg_q;
  assign wake_req        = wake_q;
  assign debug_wake_flag = wake_flag_q;
  assign soft_reset_hold = soft_reset_q;
  assign erase_busy      = em_bus.busy;
  assign prot_enabled    = prot_on_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic ctrl_hit;
  logic cpu_hit;
  assign ctrl_hit = state_q == dbg_pkg::ST_IDLE && new_req && dbg_q &&
                    hold_q.sel == `AP_SEL_CTRL;
  assign cpu_hit  = state_q == dbg_pkg::ST_IDLE && new_req && dbg_q &&
                    hold_q.sel == `AP_SEL_CPU;

  cpu_forward_a: assert property (cpu_hit && !prot_on_q |=>            // R1
    cpu_req_q && cpu_addr_q == $past(hold_q.addr))
    else $error("cpu port request not forwarded");
  prot_refuse_a: assert property (cpu_hit && prot_on_q |=>             // R2
    !cpu_req_q && rsp_err_q && ack_tgl_q != $past(ack_tgl_q))
    else $error("protected cpu port request not refused");
  ctrl_open_a: assert property (ctrl_hit |=>                           // R3
    !rsp_err_q && ack_tgl_q != $past(ack_tgl_q))
    else $error("control port request not answered");
  erase_lifts_a: assert property ($fell(em_bus.busy) |-> ##2 !prot_on_q) // R4
    else $error("protection still on after erase");
  soft_hold_a: assert property (ctrl_hit && hold_q.write &&            // R5
    hold_q.addr == `OFS_SOFT_RESET |=> soft_reset_hold == $past(hold_q.wdata[`CMD_BIT]))
    else $error("soft reset bit not applied");
  erase_noop_a: assert property (ctrl_hit && hold_q.write &&           // R6
    hold_q.addr == `OFS_ERASE_CMD && !hold_q.wdata[`CMD_BIT] && !em_bus.busy
    |=> ##1 !em_bus.busy)
    else $error("erase started by a zero write");
  busy_read_a: assert property (ctrl_hit && !hold_q.write &&           // R7
    hold_q.addr == `OFS_ERASE_STAT |=> rsp_data_q == {31'h0, $past(em_bus.busy)})
    else $error("erase status read wrong");
  prot_read_a: assert property (ctrl_hit && !hold_q.write &&           // R8
    hold_q.addr == `OFS_PROT_STAT |=> rsp_data_q[0] == !$past(prot_on_q))
    else $error("protection status read wrong");
  id_read_a: assert property (ctrl_hit && !hold_q.write &&             // R9
    hold_q.addr == `OFS_PORT_ID |=> rsp_data_q == ID_WORD)
    else $error("identification read wrong");
  early_access_a: assert property (state_q == dbg_pkg::ST_IDLE &&      // R10
    new_req && !dbg_q |=> rsp_err_q && !cpu_req_q)
    else $error("access before power request not refused");
  wake_set_a: assert property (pwr_s2_q && !dbg_q && system_off |=>    // R11
    wake_req && debug_wake_flag ##1 !wake_req)
    else $error("wake from off not flagged");
  mode_on_a: assert property (pwr_s2_q [*2] |-> debug_mode)            // R12
    else $error("debug mode not held with power request");
  mode_off_a: assert property (!pwr_s2_q [*2] |-> !debug_mode)         // R12
    else $error("debug mode not left");
  cfg_field_a: assert property (em_bus.rd_data[7:0] == `PROT_OFF_VALUE // R14
    |=> !prot_enabled)
    else $error("all ones config left protection on");
  busy_start_a: assert property (erase_start_q && !em_bus.busy |=>     // R15
    em_bus.busy [*2])
    else $error("erase busy not raised after acceptance");

  erase_run_c: cover property (erase_start_q ##1 em_bus.busy ##[1:300] !em_bus.busy);
  cpu_access_c: cover property (cpu_req_q ##[1:20] cpu_ack);
  refused_c: cover property (cpu_hit && prot_on_q);
  wake_c: cover property (wake_req);

endmodule : debug_control_access_port

/* File: test/debugger_probe.sv */
`timescale 1ns/1ps

// Debugger probe: link clock, power request and access port requests
module debugger_probe (
  // Link towards the block
  output logic             swd_clk,
  output logic             ap_req,
  output logic             ap_sel,
  output logic             ap_write,
  output logic [7:0]       ap_addr,
  output logic [31:0]      ap_wdata,
  output logic             pwr_req,
  input  wire logic        ap_done,
  input  wire logic [31:0] ap_rdata,
  input  wire logic        ap_err
);
  logic run = 1'b1;

  // Link clock idles low between accesses, as the pull-down leaves it
  always #80 swd_clk = run ? (swd_clk !== 1'b1) : 1'b0;

  initial begin
    ap_req   = 1'b0;
    ap_sel   = 1'b0;
    ap_write = 1'b0;
    ap_addr  = 8'h00;
    ap_wdata = 32'h0;
    pwr_req  = 1'b0;
  end

  // Power request level; the test raises it after one unpowered access and drops it at session end
  task power(input logic on);
    pwr_req = on;
  endtask : power

  // One access: request for one cycle, then wait for the answer
  task access(input logic s, input logic w, input logic [7:0] a,
              input logic [31:0] d, output logic [31:0] q, output logic e,
              output logic ok);
    ok  = 1'b0;
    run = 1'b1;
    @(negedge swd_clk);
    {ap_req, ap_sel, ap_write, ap_addr, ap_wdata} = {1'b1, s, w, a, d};
    @(negedge swd_clk);
    // Released fields carry no stale copy of the request
    {ap_req, ap_sel, ap_write, ap_addr, ap_wdata} = {1'b0, ~s, ~w, ~a, ~d};
    for (int n = 0; n < 100 && !ok; n++) begin
      @(posedge swd_clk);
      #1;
      if (ap_done === 1'b1) begin
        q  = ap_rdata;
        e  = ap_err;
        ok = 1'b1;
      end
    end
    @(negedge swd_clk);
    run = 1'b0;
  endtask : access
endmodule : debugger_probe

/* File: test/debug_control_access_port_tb_top.sv */
`timescale 1ns/1ps

module debug_control_access_port_tb_top;
  localparam int          DEPTH = 64;
  // Identity values are arbitrary
  localparam logic [31:0] ID_WORD = {4'h3, 4'h0, 7'h15, 4'h8, 5'h00, 8'h5c};

  logic        sys_clk = 1'b0;
  logic        rst, swd_clk, ap_req, ap_sel, ap_write, pwr_req, ap_done, ap_err;
  logic [7:0]  ap_addr, cpu_addr, a_l, ad;
  logic [31:0] ap_wdata, ap_rdata, cpu_wdata, cpu_rdata, prog_data, q, cpu_last, d_l, rd;
  logic        cpu_req, cpu_write, cpu_ack, prog_we, system_off, wake_flag_clr, w_l;
  logic [5:0]  prog_addr;
  logic        debug_mode, wake_req, debug_wake_flag, soft_reset_hold, erase_busy;
  logic        prot_enabled, e, ok, w;
  logic [7:0]  offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'hfc, 8'h10};
  int          failures, num_checks, n0;
  int          cpu_seen = 0, busy_cnt = 0, wake_cnt = 0;

  always #50 sys_clk = ~sys_clk;

  debugger_probe debugger_probe_i (.swd_clk(swd_clk), .ap_req(ap_req), .ap_sel(ap_sel),
    .ap_write(ap_write), .ap_addr(ap_addr), .ap_wdata(ap_wdata), .pwr_req(pwr_req),
    .ap_done(ap_done), .ap_rdata(ap_rdata), .ap_err(ap_err));

  debug_control_access_port #(.DEPTH(DEPTH), .ID_REVISION(4'h3),
    .ID_CLASS(4'h8), .ID_PORT_IDENTIFIER_FIELD(8'h5c)) debug_control_access_port_i (
    .sys_clk(sys_clk), .rst(rst), .swd_clk(swd_clk), .ap_req(ap_req), .ap_sel(ap_sel),
    .ap_write(ap_write), .ap_addr(ap_addr), .ap_wdata(ap_wdata), .pwr_req(pwr_req),
    .ap_done(ap_done), .ap_rdata(ap_rdata), .ap_err(ap_err), .cpu_req(cpu_req),
    .cpu_write(cpu_write), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_ack(cpu_ack),
    .cpu_rdata(cpu_rdata), .prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data),
    .system_off(system_off), .wake_flag_clr(wake_flag_clr), .debug_mode(debug_mode),
    .wake_req(wake_req), .debug_wake_flag(debug_wake_flag),
    .soft_reset_hold(soft_reset_hold), .erase_busy(erase_busy), .prot_enabled(prot_enabled));

  // CPU port core answers after a random stall with fresh data each cycle
  always @(negedge sys_clk) begin
    cpu_rdata <= $urandom;
    cpu_ack   <= cpu_req & ($urandom_range(0, 2) == 0);
  end

  // Record what the core took, count busy cycles and wake pulses
  always @(posedge sys_clk) begin
    if (cpu_req === 1'b1 && cpu_ack === 1'b1) begin
      {cpu_last, w_l, a_l, d_l} <= {cpu_rdata, cpu_write, cpu_addr, cpu_wdata};
      cpu_seen <= cpu_seen + 1;
    end
    if (erase_busy === 1'b1) busy_cnt <= busy_cnt + 1;
    if (wake_req === 1'b1) wake_cnt <= wake_cnt + 1;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] exp_reg(input logic [7:0] a, input logic rs,
                                          input logic bsy, input logic prot);
    case (a)
      8'h00:   exp_reg = {31'h0, rs};
      8'h08:   exp_reg = {31'h0, bsy};
      8'h0c:   exp_reg = {31'h0, ~prot};
      8'hfc:   exp_reg = ID_WORD;
      default: exp_reg = 32'h0;
    endcase
  endfunction : exp_reg

  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task acc(input logic s, input logic wr, input logic [7:0] a, input logic [31:0] d);
    debugger_probe_i.access(s, wr, a, d, q, e, ok);
    // Realign to the system clock so later stimulus lands on its falling edge
    @(negedge sys_clk);
    if (ok !== 1'b1) begin
      failures++;
      complete_run;
    end
  endtask : acc

  // Bounded wait: 0 debug_mode, 1 erase_busy, 2 prot_enabled
  task wait_for(input int k, input logic v);
    logic s;
    for (int n = 0; n < 300; n++) begin
      @(negedge sys_clk);
      s = (k == 0) ? debug_mode : (k == 1) ? erase_busy : prot_enabled;
      if (s === v) return;
    end
    failures++;
    complete_run;
  endtask : wait_for

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {rst, prog_we, prog_addr, prog_data} = {1'b1, 1'b0, 6'h0, 32'h0};
    {system_off, wake_flag_clr} = 2'b00;
    {failures, num_checks} = '0;
    rd = $urandom(6);
    // Reset must reach the link side too, so wait for its clock as well
    fork
      repeat (3) @(negedge sys_clk);
      repeat (3) @(posedge swd_clk);
    join
    @(negedge sys_clk);
    rst = 1'b0;
    // Link side leaves reset two of its own edges later; no request before that
    repeat (3) @(posedge swd_clk);
    wait_for(2, 1'b0);
    check(soft_reset_hold, 1'b0);
    acc(1'b1, 1'b0, 8'hfc, 32'h0);
    check(e, 1'b1);
    $display("test reset and unpowered access done");

    system_off = 1'b1;
    debugger_probe_i.power(1'b1);
    wait_for(0, 1'b1);
    repeat (3) @(negedge sys_clk);
    check(wake_cnt, 1);
    check(debug_wake_flag, 1'b1);
    {system_off, wake_flag_clr} = 2'b01;
    @(negedge sys_clk);
    wake_flag_clr = 1'b0;
    @(negedge sys_clk);
    check(debug_wake_flag, 1'b0);
    $display("test wake done");

    // Every control offset plus an unmapped one, with junk write data
    for (int i = 0; i < 6; i++) begin
      acc(1'b1, 1'b0, offs[i], $urandom);
      check(e, 1'b0);
      check(q, exp_reg(offs[i], 1'b0, 1'b0, 1'b0));
    end
    acc(1'b1, 1'b1, 8'h00, 32'h1);
    check(soft_reset_hold, 1'b1);
    acc(1'b1, 1'b0, 8'h00, 32'h0);
    check(q, 32'h1);
    acc(1'b1, 1'b1, 8'h00, 32'hfffffffe);
    check(soft_reset_hold, 1'b0);
    $display("test control registers done");

    for (int i = 0; i < 8; i++) begin
      w = $urandom_range(0, 1);
      rd = $urandom;
      ad = 8'($urandom);
      n0 = cpu_seen;
      acc(1'b0, w, ad, rd);
      check(cpu_seen, n0 + 1);
      check(e, 1'b0);
      check(q, cpu_last);
      check({23'h0, w_l, a_l}, {23'h0, w, ad});
      if (w) check(d_l, rd);
    end
    $display("test cpu port done");

    // A word outside the config slot must leave protection off
    {prog_we, prog_addr, prog_data} = {1'b1, 6'($urandom_range(1, DEPTH - 1)), 32'h0};
    @(negedge sys_clk);
    prog_we = 1'b0;
    repeat (3) @(negedge sys_clk);
    check(prot_enabled, 1'b0);
    // Config word with protection field not all ones
    {prog_we, prog_addr, prog_data} = {1'b1, 6'h0, $urandom & 32'hffffff00};
    @(negedge sys_clk);
    prog_we = 1'b0;
    wait_for(2, 1'b1);
    n0 = cpu_seen;
    acc(1'b0, 1'b0, 8'($urandom), 32'h0);
    check(e, 1'b1);
    check(q, 32'h0);
    check(cpu_seen, n0);
    for (int i = 3; i < 5; i++) begin
      acc(1'b1, 1'b0, offs[i], 32'h0);
      check(q, exp_reg(offs[i], 1'b0, 1'b0, 1'b1));
    end
    $display("test protection done");

    acc(1'b1, 1'b1, 8'h04, 32'hfffffffe);
    repeat (5) @(negedge sys_clk);
    check(erase_busy, 1'b0);
    n0 = busy_cnt;
    acc(1'b1, 1'b1, 8'h04, 32'h1);
    acc(1'b1, 1'b0, 8'h08, 32'h0);
    check(q, 32'h1);
    wait_for(1, 1'b0);
    check(busy_cnt - n0, DEPTH);
    check(prot_enabled, 1'b0);
    for (int i = 2; i < 4; i++) begin
      acc(1'b1, 1'b0, offs[i], 32'h0);
      check(q, exp_reg(offs[i], 1'b0, 1'b0, 1'b0));
    end
    $display("test erase done");

    debugger_probe_i.power(1'b0);
    wait_for(0, 1'b0);
    acc(1'b1, 1'b0, 8'hfc, 32'h0);
    check(e, 1'b1);
    $display("test power drop done");
    complete_run;
  end
endmodule : debug_control_access_port_tb_top
